// [src/cpu_bus_sideband_control.v]
// cpu_bus_sideband_control.v: fp error pin, flush request, inquire results, bus hold handshake
// assumes: core events arrive as one-cycle pulses on clk; pins from the chipset are asynchronous
//
// Operation
// - raise fp error only at boundary of next fp, packed or wait instruction
// - fp error ignores numeric error control bit and ignore input
// - drop fp error on clear, init, save, store env; maybe on loads; after reset
// - fp error comes straight from a flip-flop, so it never glitches
// - fp error, hit, hit modified and hold ack always driven except test mode
// - flush: write back modified lines, invalidate all, then flush-ack special cycle
// - flush request low at reset release enters float test mode
// - flush request latched on falling edge, acted on at next instruction boundary
// - strap taken on the first edge after reset is seen negated
// - hit reports valid line, updated only the edge after strobe, held until next
// - hit modified on modified line starts writeback unless already writing it back
// - hit modified drops one edge after final burst ready of its writeback
// - hold request: finish cycles, wait out locked sequence, float bus, acknowledge
// - hold ack one edge after last burst ready, or after request if idle
// - hold ack drops one edge after hold request seen negated
// - bus outputs floated every clock hold ack is high
// - hold ack ignores backoff and comes from a flip-flop
// - hold request sampled every clock edge
// - strobe sampled from two edges after hold ack was raised
`timescale 1ns/1ps
`include "sideband_defs.vh"

module cpu_bus_sideband_control #(
  parameter WB_BEATS = `WB_BEATS
) (
  clk,
  rst_n,
  clk_en,
  cache_flush_req_n,
  hold_req,
  ext_addr_strobe_n,
  burst_ready_n,
  backoff_n,
  instr_boundary,
  fp_exception,
  fp_target_instr,
  fp_clear_instr,
  fp_load_clear_instr,
  bus_cycle_active,
  bus_cycle_last,
  locked_seq,
  inq_valid_hit,
  inq_modified_hit,
  inq_wb_in_progress,
  flush_wb_pending,
  flush_wb_done,
  flush_ack_done,
  float_test_mode,
  fp_error_out_n,
  fp_error_oe,
  inquire_hit_n,
  inquire_hit_oe,
  inquire_hit_modified_n,
  inquire_hit_modified_oe,
  hold_ack,
  hold_ack_oe,
  bus_float,
  inquire_lookup,
  inquire_wb_start,
  flush_wb_start,
  flush_invalidate,
  flush_ack_cycle
);
  input  wire clk;
  input  wire rst_n;
  input  wire clk_en;
  input  wire cache_flush_req_n;    // pin, active low
  input  wire hold_req;             // pin
  input  wire ext_addr_strobe_n;    // pin, active low
  input  wire burst_ready_n;        // bus unit, same clock
  input  wire backoff_n;            // deliberately unused for hold
  input  wire instr_boundary;       // core pulse
  input  wire fp_exception;         // unmasked fp exception pulse
  input  wire fp_target_instr;      // boundary is fp, packed or wait instruction
  input  wire fp_clear_instr;       // clear, init, save or store env completed
  input  wire fp_load_clear_instr;  // load that chose to clear the error
  input  wire bus_cycle_active;
  input  wire bus_cycle_last;       // current burst ready ends the cycle
  input  wire locked_seq;
  input  wire inq_valid_hit;
  input  wire inq_modified_hit;
  input  wire inq_wb_in_progress;
  input  wire flush_wb_pending;
  input  wire flush_wb_done;
  input  wire flush_ack_done;
  output reg  float_test_mode;
  output reg  fp_error_out_n;
  output reg  fp_error_oe;
  output reg  inquire_hit_n;
  output reg  inquire_hit_oe;
  output reg  inquire_hit_modified_n;
  output reg  inquire_hit_modified_oe;
  output reg  hold_ack;
  output reg  hold_ack_oe;
  output reg  bus_float;
  output reg  inquire_lookup;
  output reg  inquire_wb_start;
  output reg  flush_wb_start;
  output reg  flush_invalidate;
  output reg  flush_ack_cycle;

  // state codes; flush sequence runs strictly in order
  localparam [1:0]  HS_IDLE        = 2'h0;
  localparam [1:0]  HS_WAIT        = 2'h1;
  localparam [1:0]  HS_GRANT       = 2'h2;
  localparam [2:0]  FL_IDLE        = 3'h0;
  localparam [2:0]  FL_WRITEBACK   = 3'h1;
  localparam [2:0]  FL_INVALIDATE  = 3'h2;
  localparam [2:0]  FL_ACK         = 3'h3;
  localparam [2:0]  FL_DONE        = 3'h4;
  // preload so the strobe is first taken the second edge after hold ack
  localparam [31:0] EXT_ADDR_STROBE_WAIT_FULL = `HOLD_EXT_ADDR_STROBE_DELAY - 1;

  // synchronised pins
  wire flush_lvl;
  wire hold_lvl;
  wire ext_addr_strobe_lvl;

  // kept out of reset: the strap level must already be through the flops at release
  pin_sync #(.RESET_VAL(1'b1)) u_sync_flush (
    .clk    (clk),
    .rst_n  (1'b1),
    .clk_en (clk_en),
    .pin    (cache_flush_req_n),
    .level  (flush_lvl)
  );

  pin_sync #(.RESET_VAL(1'b0)) u_sync_hold (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .pin    (hold_req),
    .level  (hold_lvl)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sync_ext_addr_strobe (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .pin    (ext_addr_strobe_n),
    .level  (ext_addr_strobe_lvl)
  );

  reg                start_q;       // first enabled edge after reset release
  reg                fp_pend_q;
  reg                flush_prev_q;
  reg                flush_pend_q;
  reg  [2:0]         fl_state_q;
  reg  [1:0]         hs_state_q;
  reg  [1:0]         ext_addr_strobe_wait_q;
  reg                ext_addr_strobe_block_q;  // ignore strobe one edge after a sample
  reg                inquire_hit_modified_wb_q;     // hit modified waiting on its writeback
  reg  [`BEAT_W-1:0] beat_q;

  wire burst_ready       = ~burst_ready_n;
  wire test_off   = ~float_test_mode;
  wire ext_addr_strobe_ok    = hold_ack ? (ext_addr_strobe_wait_q == 2'h0) : 1'b1;
  wire ext_addr_strobe_seen  = ~ext_addr_strobe_lvl & ext_addr_strobe_ok & ~ext_addr_strobe_block_q & inquire_hit_modified_n;
  wire last_beat  = burst_ready & (beat_q == WB_BEATS[`BEAT_W-1:0] - 1'b1);
  wire hold_clear = (~bus_cycle_active | (burst_ready & bus_cycle_last)) & ~locked_seq;

  // strap capture: reset-time level of the flush pin decides test mode
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_q         <= 1'b1;
      float_test_mode <= 1'b0;
    end
    else if (clk_en)
    begin
      start_q <= 1'b0;
      if (start_q)
        float_test_mode <= ~flush_lvl;
    end
  end

  // output enables follow test mode; all pins driven otherwise
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fp_error_oe             <= 1'b1;
      inquire_hit_oe          <= 1'b1;
      inquire_hit_modified_oe <= 1'b1;
      hold_ack_oe             <= 1'b1;
    end
    else if (clk_en)
    begin
      fp_error_oe             <= test_off;
      inquire_hit_oe          <= test_off;
      inquire_hit_modified_oe <= test_off;
      hold_ack_oe             <= test_off;
    end
  end

  // fp error: pending on exception, shown at target boundary, registered output
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fp_pend_q      <= 1'b0;
      fp_error_out_n <= 1'b1;
    end
    else if (clk_en)
    begin
      if (fp_exception)
        fp_pend_q <= 1'b1;
      else if (instr_boundary & fp_target_instr)
        fp_pend_q <= 1'b0;
      // new exception wins over a clear in the same cycle via the pending flag
      if (fp_pend_q & instr_boundary & fp_target_instr)
        fp_error_out_n <= 1'b0;
      else if (fp_clear_instr | fp_load_clear_instr)
        fp_error_out_n <= 1'b1;
    end
  end

  // flush request: falling-edge latch, served at an instruction boundary
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flush_prev_q     <= 1'b1;
      flush_pend_q     <= 1'b0;
      fl_state_q       <= FL_IDLE;
      flush_wb_start   <= 1'b0;
      flush_invalidate <= 1'b0;
      flush_ack_cycle  <= 1'b0;
    end
    else if (clk_en)
    begin
      flush_prev_q     <= flush_lvl;
      flush_wb_start   <= 1'b0;
      flush_invalidate <= 1'b0;
      flush_ack_cycle  <= 1'b0;
      if (flush_prev_q & ~flush_lvl & ~start_q & test_off)
        flush_pend_q <= 1'b1;
      else if (fl_state_q == FL_IDLE && flush_pend_q && instr_boundary)
        flush_pend_q <= 1'b0;
      case (fl_state_q)
        FL_IDLE:
        begin
          if (flush_pend_q & instr_boundary)
          begin
            fl_state_q     <= FL_WRITEBACK;
            flush_wb_start <= 1'b1;
          end
        end
        FL_WRITEBACK:
        begin
          if (flush_wb_done | ~flush_wb_pending)
          begin
            fl_state_q       <= FL_INVALIDATE;
            flush_invalidate <= 1'b1;
          end
        end
        FL_INVALIDATE:
        begin
          fl_state_q      <= FL_ACK;
          flush_ack_cycle <= 1'b1;
        end
        FL_ACK:
        begin
          if (flush_ack_done)
            fl_state_q <= FL_DONE;
        end
        FL_DONE:
          fl_state_q <= FL_IDLE;
        default:
          fl_state_q <= FL_IDLE;
      endcase
    end
  end

  // hold handshake; backoff plays no part
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hs_state_q  <= HS_IDLE;
      hold_ack    <= 1'b0;
      bus_float   <= 1'b0;
      ext_addr_strobe_wait_q <= 2'h0;
    end
    else if (clk_en)
    begin
      if (ext_addr_strobe_wait_q != 2'h0)
        ext_addr_strobe_wait_q <= ext_addr_strobe_wait_q - 2'h1;
      case (hs_state_q)
        HS_IDLE, HS_WAIT:
        begin
          if (!hold_lvl)
            hs_state_q <= HS_IDLE;
          else if (hold_clear)
          begin
            hs_state_q  <= HS_GRANT;
            hold_ack    <= 1'b1;
            bus_float   <= 1'b1;
            ext_addr_strobe_wait_q <= EXT_ADDR_STROBE_WAIT_FULL[1:0];
          end
          else
            hs_state_q <= HS_WAIT;
        end
        HS_GRANT:
        begin
          if (!hold_lvl)
          begin
            hs_state_q <= HS_IDLE;
            hold_ack   <= 1'b0;
            bus_float  <= 1'b0;
          end
        end
        default:
          hs_state_q <= HS_IDLE;
      endcase
    end
  end

  // inquire results: set the edge after a sampled strobe; hit modified also clears after its writeback
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inquire_hit_n          <= 1'b1;
      inquire_hit_modified_n <= 1'b1;
      inquire_lookup         <= 1'b0;
      inquire_wb_start       <= 1'b0;
      ext_addr_strobe_block_q           <= 1'b0;
      inquire_hit_modified_wb_q              <= 1'b0;
      beat_q                 <= {`BEAT_W{1'b0}};
    end
    else if (clk_en)
    begin
      inquire_lookup   <= ext_addr_strobe_seen;
      inquire_wb_start <= 1'b0;
      ext_addr_strobe_block_q     <= ext_addr_strobe_seen;
      if (ext_addr_strobe_seen)
      begin
        inquire_hit_n          <= ~inq_valid_hit;
        inquire_hit_modified_n <= ~inq_modified_hit;
        inquire_wb_start       <= inq_modified_hit & ~inq_wb_in_progress;
        inquire_hit_modified_wb_q              <= inq_modified_hit;
        beat_q                 <= {`BEAT_W{1'b0}};
      end
      else if (inquire_hit_modified_wb_q & burst_ready)
      begin
        beat_q <= beat_q + 1'b1;
        if (last_beat)
        begin
          inquire_hit_modified_wb_q              <= 1'b0;
          inquire_hit_modified_n <= 1'b1;
        end
      end
    end
  end
endmodule // cpu_bus_sideband_control

// [inc/sideband_defs.vh]
// sideband_defs.vh: constants for the processor bus sideband block
// assumes: included by bare name from the design files under src/
`ifndef SIDEBAND_DEFS_VH
`define SIDEBAND_DEFS_VH

// input synchroniser depth for pins from outside the clock domain
`define SYNC_STAGES        3
// edges after hold_ack rises before ext_addr_strobe is sampled
`define HOLD_EXT_ADDR_STROBE_DELAY    2
// beats in a writeback burst
`define WB_BEATS           4
// width of the beat counter
`define BEAT_W             3

`endif

// [src/pin_sync.v]
// pin_sync.v: three-stage synchroniser with agreement filter for one pin
// assumes: pin is asynchronous to clk; output changes once stages two and three agree
`timescale 1ns/1ps
`include "sideband_defs.vh"

module pin_sync #(
  parameter RESET_VAL = 1'b1
) (
  clk,
  rst_n,
  clk_en,
  pin,
  level
);
  input  wire clk;
  input  wire rst_n;
  input  wire clk_en;
  input  wire pin;
  output reg  level;

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // first stage feeds only the second; filter looks at two and three
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q  <= RESET_VAL;
      s2_q  <= RESET_VAL;
      s3_q  <= RESET_VAL;
      level <= RESET_VAL;
    end
    else if (clk_en)
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level <= s3_q;
    end
  end
endmodule // pin_sync

// [test/cpu_bus_sideband_control_asserts.sv]
// cpu_bus_sideband_control_asserts.sv: port timing checks for the sideband block
// assumes: bound into the design top; one clock, async active-low reset
`timescale 1ns/1ps

module cpu_bus_sideband_control_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold_req,
  input wire logic burst_ready_n,
  input wire logic instr_boundary,
  input wire logic fp_target_instr,
  input wire logic fp_clear_instr,
  input wire logic fp_load_clear_instr,
  input wire logic bus_cycle_active,
  input wire logic bus_cycle_last,
  input wire logic locked_seq,
  input wire logic float_test_mode,
  input wire logic fp_error_out_n,
  input wire logic fp_error_oe,
  input wire logic inquire_hit_n,
  input wire logic inquire_hit_oe,
  input wire logic inquire_hit_modified_n,
  input wire logic inquire_hit_modified_oe,
  input wire logic hold_ack,
  input wire logic hold_ack_oe,
  input wire logic bus_float,
  input wire logic inquire_lookup
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // hold side: float, lock, cycle end, release
  chk_float_ack: assert property (hold_ack |-> bus_float)
    else $error("bus not floated under hold ack");
  chk_ack_unlocked: assert property ($rose(hold_ack) |-> !$past(locked_seq))
    else $error("hold ack inside locked sequence");
  chk_ack_cycle_end: assert property ($rose(hold_ack) |-> !$past(bus_cycle_active) ||
    ($past(bus_cycle_last) && !$past(burst_ready_n))) else $error("hold ack before cycle end");
  chk_ack_release: assert property (!hold_req [*8] |-> !hold_ack)
    else $error("hold ack kept after request dropped");
  // fp error: set only at target boundary, sticky, cleared
  chk_err_boundary: assert property ($fell(fp_error_out_n) |-> $past(instr_boundary) && $past(fp_target_instr))
    else $error("fp error raised off a target boundary");
  chk_err_sticky: assert property (!fp_error_out_n && !fp_clear_instr && !fp_load_clear_instr |=> !fp_error_out_n)
    else $error("fp error dropped without a clear");
  chk_err_clear: assert property (fp_clear_instr && !instr_boundary |=> fp_error_out_n)
    else $error("fp error kept after clear");
  // pins driven outside test mode; inquire results move only when due
  chk_pins_driven: assert property (!float_test_mode |-> fp_error_oe && inquire_hit_oe &&
    inquire_hit_modified_oe && hold_ack_oe) else $error("pin floated in normal mode");
  chk_inquire_hit_modified_release: assert property ($rose(inquire_hit_modified_n) |-> $past(burst_ready_n) == 1'b0)
    else $error("hit modified dropped off a burst ready");
  chk_hit_update: assert property (!$stable(inquire_hit_n) |-> inquire_lookup)
    else $error("hit changed without an inquiry");
endmodule // cpu_bus_sideband_control_asserts

bind cpu_bus_sideband_control cpu_bus_sideband_control_asserts i_chk (.*);

// [test/chipset_model.sv]
// chipset_model.sv: far-side chipset driving hold, inquire strobe and burst ready
// assumes: bench commands change just after rising clk edges
`timescale 1ns/1ps

module chipset_model (
  input  wire logic       clk,
  input  wire logic       want_hold,
  input  wire logic       inq_go,
  input  wire logic       burst_ready_go,
  input  wire logic [3:0] beats,
  output logic            hold_req,
  output wire logic       ext_addr_strobe_n,
  output wire logic       burst_ready_n
);
  logic [1:0] strobe_q = 2'h0;
  logic [3:0] left_q   = 4'h0;
  logic       gap_q    = 1'b0;

  // strobe held two clocks so the synchroniser agrees; beats every other clock
  always @(posedge clk)
  begin
    hold_req <= want_hold;
    gap_q    <= ~gap_q;
    if (inq_go)
      strobe_q <= 2'h2;
    else if (strobe_q != 2'h0)
      strobe_q <= strobe_q - 2'h1;
    if (burst_ready_go)
      left_q <= beats;
    else if (gap_q && left_q != 4'h0)
      left_q <= left_q - 4'h1;
  end

  // no address strobe expected per hit modified; ready line idles high
  assign ext_addr_strobe_n = (strobe_q == 2'h0);
  assign burst_ready_n     = ~(gap_q && left_q != 4'h0);
endmodule // chipset_model

// [test/tb.sv]
// tb.sv: self-checking bench for the bus sideband block
// assumes: design, checker and chipset model compiled first
`timescale 1ns/1ps

module tb;
  logic       clk, rst_n, clk_en, cache_flush_req_n, backoff_n, fp_target_instr;
  logic       bus_cycle_active, bus_cycle_last, locked_seq, inq_valid_hit, inq_modified_hit;
  logic       inq_wb_in_progress, flush_wb_pending, want_hold;
  logic [3:0] beats;
  logic [7:0] pls;
  wire        inq_go, instr_boundary, fp_exception, fp_clear_instr, fp_load_clear_instr;
  wire        flush_wb_done, flush_ack_done, hold_req, ext_addr_strobe_n, burst_ready_n;
  wire        float_test_mode, fp_error_out_n, fp_error_oe, inquire_hit_n, inquire_hit_oe;
  wire        inquire_hit_modified_n, inquire_hit_modified_oe, hold_ack, hold_ack_oe, bus_float;
  wire        inquire_lookup, inquire_wb_start, flush_wb_start, flush_invalidate, flush_ack_cycle;
  wire        burst_ready_go = pls[7] | inquire_wb_start;
  wire [4:0]  obs = {hold_ack, inquire_hit_modified_n, flush_wb_start, flush_invalidate, flush_ack_cycle};
  int         failures, compares, cycles;

  // one-clock pulses all come from one vector
  assign {flush_ack_done, flush_wb_done, fp_load_clear_instr, fp_clear_instr} = pls[6:3];
  assign {fp_exception, instr_boundary, inq_go} = pls[2:0];

  cpu_bus_sideband_control #(.WB_BEATS(4)) i_dut (.*);
  chipset_model i_chipset (.*);

  // 200 MHz bus clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      final_report;
    end
  end

  task chk(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task pulse(input int b);
    @(posedge clk);
    pls[b] <= 1'b1;
    @(posedge clk);
    pls[b] <= 1'b0;
    #1;
  endtask

  // bounded wait on one observed output
  task wt(input string what, input int b, input logic v);
    int n;
    n = 0;
    while (obs[b] !== v && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(what, v, obs[b]);
  endtask

  // strap held long before and after release, well past the sync depth
  task do_reset(input logic strap);
    @(posedge clk);
    rst_n             <= 1'b0;
    cache_flush_req_n <= strap;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    tick(6);
  endtask

  task t_hold;
    @(posedge clk);
    locked_seq <= 1'b1;
    want_hold  <= 1'b1;
    backoff_n  <= 1'b0;
    tick(12);
    chk("ack_locked", 1'b0, hold_ack);
    @(posedge clk);
    locked_seq <= 1'b0;
    wt("ack_idle", 4, 1'b1);
    chk("float", 1'b1, bus_float);
    tick(2);
    @(posedge clk);
    inq_valid_hit    <= 1'b1;
    inq_modified_hit <= 1'b1;
    pulse(0);
    wt("inquire_hit_modified", 3, 1'b0);
    chk("hit", 1'b0, inquire_hit_n);
    wt("inquire_hit_modified_drop", 3, 1'b1);
    chk("hit_held", 1'b0, inquire_hit_n);
    @(posedge clk);
    inq_wb_in_progress <= 1'b1;
    pulse(0);
    wt("inquire_hit_modified_busy", 3, 1'b0);
    chk("no_second_wb", 1'b0, inquire_wb_start);
    pulse(7);
    wt("inquire_hit_modified_busy_drop", 3, 1'b1);
    @(posedge clk);
    want_hold          <= 1'b0;
    backoff_n          <= 1'b1;
    inq_wb_in_progress <= 1'b0;
    wt("ack_drop", 4, 1'b0);
    chk("float_off", 1'b0, bus_float);
    $display("t_hold done");
  endtask

  task t_busy;
    @(posedge clk);
    bus_cycle_active <= 1'b1;
    bus_cycle_last   <= 1'b1;
    beats            <= 4'h1;
    want_hold        <= 1'b1;
    tick(12);
    chk("ack_busy", 1'b0, hold_ack);
    pulse(7);
    wt("ack_after", 4, 1'b1);
    @(posedge clk);
    bus_cycle_active <= 1'b0;
    want_hold        <= 1'b0;
    beats            <= 4'h4;
    wt("ack_drop", 4, 1'b0);
    $display("t_busy done");
  endtask

  // pass 0 ends the writeback on a done pulse, pass 1 with nothing pending
  task t_flush;
    int k;
    for (k = 0; k < 2; k++)
    begin
      @(posedge clk);
      flush_wb_pending  <= (k == 0);
      cache_flush_req_n <= 1'b0;
      tick(3);
      @(posedge clk);
      cache_flush_req_n <= 1'b1;
      repeat (8)
      begin
        tick(1);
        chk("flush_early", 1'b0, flush_wb_start);
      end
      pulse(1);
      wt("wb_start", 2, 1'b1);
      if (k == 0)
        pulse(5);
      wt("invalidate", 1, 1'b1);
      wt("flush_ack", 0, 1'b1);
      pulse(6);
    end
    $display("t_flush done");
  endtask

  task t_fperr;
    pulse(2);
    tick(4);
    chk("err_early", 1'b1, fp_error_out_n);
    pulse(1);
    chk("err_other", 1'b1, fp_error_out_n);
    @(posedge clk);
    fp_target_instr <= 1'b1;
    pulse(1);
    chk("err_set", 1'b0, fp_error_out_n);
    tick(10);
    chk("err_stays", 1'b0, fp_error_out_n);
    pulse(4);
    chk("err_load_clr", 1'b1, fp_error_out_n);
    pulse(2);
    pulse(1);
    chk("err_again", 1'b0, fp_error_out_n);
    pulse(3);
    chk("err_clr", 1'b1, fp_error_out_n);
    pulse(2);
    pulse(1);
    $display("t_fperr done");
  endtask

  task t_strap;
    do_reset(1'b0);
    chk("test_mode", 1'b1, float_test_mode);
    chk("err_oe", 1'b0, fp_error_oe);
    chk("ack_oe", 1'b0, hold_ack_oe);
    chk("err_cleared", 1'b1, fp_error_out_n);
    do_reset(1'b1);
    chk("normal_mode", 1'b0, float_test_mode);
    chk("inquire_hit_modified_oe", 1'b1, inquire_hit_modified_oe);
    chk("err_reset", 1'b1, fp_error_out_n);
    $display("t_strap done");
  endtask

  task final_report;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence; clk_en stays tied high
  initial
  begin
    {rst_n, backoff_n, clk_en, cache_flush_req_n} = 4'h7;
    {fp_target_instr, bus_cycle_active, bus_cycle_last, locked_seq} = 4'h0;
    {inq_valid_hit, inq_modified_hit, inq_wb_in_progress, flush_wb_pending, want_hold} = 5'h00;
    beats = 4'h4;
    pls   = 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    tick(6);
    chk("hit_reset", 1'b1, inquire_hit_n);
    t_hold;
    t_busy;
    t_flush;
    t_fperr;
    t_strap;
    final_report;
  end
endmodule // tb
